/* File: design/ucs_irq_ctrl.sv */
// Purpose: request flags, mask bits and start triggers of the first serial channel pair
// Assumes: register port with one-cycle strobes, read data in the next cycle
// Notes: flags are sticky and cleared by writing one; irq_out is high while an unmasked flag is set
// Notes on behaviour
// - flags read zero idle, one when raised
// - mask zero services, mask one blocks
// - start one sets enable, enters wait
// - start zero leaves channel untouched
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module ucs_irq_ctrl (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic [ucs_pkg::ADDR_W-1:0] addr_in,
    input wire logic [ucs_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [ucs_pkg::DATA_W-1:0] rdata_out,
    input wire logic rx_done_request_in,
    input wire logic tx_done_request_in,
    input wire logic rx_error_request_in,
    output logic irq_out,
    output logic [ucs_pkg::CHAN_N-1:0] channel_operation_enable_out,
    output logic [ucs_pkg::CHAN_N-1:0] receive_enable_bit_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // bundle the bus and event inputs
    ucs_pkg::ucs_bus_req_s req;
    ucs_pkg::ucs_events_s evt;
    assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
    assign evt = '{rx_done: rx_done_request_in, tx_done: tx_done_request_in, rx_error: rx_error_request_in};

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    wire wr_flags_h = req.wr && (req.addr == ucs_pkg::ADDR_FLAGS_HIGH_0);
    wire wr_flags_l = req.wr && (req.addr == ucs_pkg::ADDR_FLAGS_LOW_1);
    wire wr_masks_h = req.wr && (req.addr == ucs_pkg::ADDR_MASKS_HIGH_0);
    wire wr_masks_l = req.wr && (req.addr == ucs_pkg::ADDR_MASKS_LOW_1);
    wire wr_start = req.wr && (req.addr == ucs_pkg::ADDR_START);
    wire wr_stop = req.wr && (req.addr == ucs_pkg::ADDR_STOP);
    wire wr_rx_en = req.wr && (req.addr == ucs_pkg::ADDR_RX_ENABLE);

    ////////////////////////////////////////////////////////////////////////////////
    // flags and masks
    logic rx_done_flag;
    logic tx_done_flag;
    logic rx_error_flag;
    logic rx_done_mask;
    logic tx_done_mask;
    logic rx_error_mask;
    logic [ucs_pkg::CHAN_N-1:0] receive_enable_bit;

    // write-one clears; a request in the same cycle wins so no event is lost
    wire clr_rx_done = wr_flags_h && req.wdata[ucs_pkg::RX_DONE_BIT];
    wire clr_tx_done = wr_flags_h && req.wdata[ucs_pkg::TX_DONE_BIT];
    wire clr_rx_error = wr_flags_l && req.wdata[ucs_pkg::RX_ERROR_BIT];
    wire next_rx_done_flag = evt.rx_done || (rx_done_flag && !clr_rx_done);
    wire next_tx_done_flag = evt.tx_done || (tx_done_flag && !clr_tx_done);
    wire next_rx_error_flag = evt.rx_error || (rx_error_flag && !clr_rx_error);

    // flag registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_done_flag <= ucs_pkg::FLAG_RESET;
            tx_done_flag <= ucs_pkg::FLAG_RESET;
            rx_error_flag <= ucs_pkg::FLAG_RESET;
        end else if (ce_in) begin
            rx_done_flag <= next_rx_done_flag;
            tx_done_flag <= next_tx_done_flag;
            rx_error_flag <= next_rx_error_flag;
        end
    end

    // masks start blocked so nothing fires before software has set up the channel
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_done_mask <= ucs_pkg::MASK_RESET;
            tx_done_mask <= ucs_pkg::MASK_RESET;
            rx_error_mask <= ucs_pkg::MASK_RESET;
        end else if (ce_in) begin
            if (wr_masks_h) begin
                rx_done_mask <= req.wdata[ucs_pkg::RX_DONE_BIT];
                tx_done_mask <= req.wdata[ucs_pkg::TX_DONE_BIT];
            end
            if (wr_masks_l) begin
                rx_error_mask <= req.wdata[ucs_pkg::RX_ERROR_BIT];
            end
        end
    end

    // receive enable bits; the four-clock settle before start is left to software
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            receive_enable_bit <= ucs_pkg::ENABLE_RESET;
        end else if (ce_in && wr_rx_en) begin
            receive_enable_bit <= req.wdata[ucs_pkg::CHAN_N-1:0];
        end
    end
    assign receive_enable_bit_out = receive_enable_bit;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt output: mask zero lets a flag through, mask one blocks it
    wire serv_rx_done = rx_done_flag && !rx_done_mask;
    wire serv_tx_done = tx_done_flag && !tx_done_mask;
    wire serv_rx_error = rx_error_flag && !rx_error_mask;
    assign irq_out = serv_rx_done || serv_tx_done || serv_rx_error;

    ////////////////////////////////////////////////////////////////////////////////
    // channel start triggers: the write itself is the pulse, nothing is stored
    wire [ucs_pkg::CHAN_N-1:0] channel_start_bit = (wr_start && ce_in) ? req.wdata[ucs_pkg::CHAN_N-1:0] : '0;
    wire [ucs_pkg::CHAN_N-1:0] channel_stop_bit = (wr_stop && ce_in) ? req.wdata[ucs_pkg::CHAN_N-1:0] : '0;
    logic [ucs_pkg::CHAN_N-1:0] channel_operation_enable;
    logic [ucs_pkg::CHAN_N-1:0] channel_waiting;

    // one start/enable slice per channel
    genvar ch;
    generate
        for (ch = 0; ch < ucs_pkg::CHAN_N; ch++) begin : g_chan
            ucs_chan_start ucs_chan_start_inst (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .ce_in(ce_in),
                .start_in(channel_start_bit[ch]),
                .stop_in(channel_stop_bit[ch]),
                .enable_out(channel_operation_enable[ch]),
                .waiting_out(channel_waiting[ch])
            );
        end
    endgenerate
    assign channel_operation_enable_out = channel_operation_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // read mux; start and stop read zero, unmapped indices read zero
    wire [ucs_pkg::DATA_W-1:0] rd_flags_h = ucs_pkg::DATA_W'({rx_done_flag, 1'b0, tx_done_flag, 5'h00});
    wire [ucs_pkg::DATA_W-1:0] rd_flags_l = ucs_pkg::DATA_W'(rx_error_flag);
    wire [ucs_pkg::DATA_W-1:0] rd_masks_h = ucs_pkg::DATA_W'({rx_done_mask, 1'b0, tx_done_mask, 5'h00});
    wire [ucs_pkg::DATA_W-1:0] rd_masks_l = ucs_pkg::DATA_W'(rx_error_mask);
    wire [ucs_pkg::DATA_W-1:0] rd_status = ucs_pkg::DATA_W'({channel_waiting, channel_operation_enable});
    wire [ucs_pkg::DATA_W-1:0] rd_rx_en = ucs_pkg::DATA_W'(receive_enable_bit);
    wire [ucs_pkg::DATA_W-1:0] rd_mux =
        (req.addr == ucs_pkg::ADDR_FLAGS_HIGH_0) ? rd_flags_h :
        (req.addr == ucs_pkg::ADDR_FLAGS_LOW_1) ? rd_flags_l :
        (req.addr == ucs_pkg::ADDR_MASKS_HIGH_0) ? rd_masks_h :
        (req.addr == ucs_pkg::ADDR_MASKS_LOW_1) ? rd_masks_l :
        (req.addr == ucs_pkg::ADDR_CHAN_STATUS) ? rd_status :
        (req.addr == ucs_pkg::ADDR_RX_ENABLE) ? rd_rx_en : '0;

    // read data register; stands for the one cycle after the strobe only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= ucs_pkg::RDATA_RESET;
        end else if (ce_in) begin
            rdata_out <= req.rd ? rd_mux : ucs_pkg::RDATA_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_flag_sets_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && evt.rx_done) |=> (rx_done_flag ##1 (rx_done_flag || $past(clr_rx_done))))
        else $error("receive-complete flag not raised");

    // set must beat clear, otherwise a request arriving during the service write is lost
    a_set_beats_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && evt.rx_error && clr_rx_error) |=> rx_error_flag)
        else $error("clear beat a simultaneous error request");

    a_freeze_holds_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !ce_in |=> ($stable(rx_done_flag) && $stable(tx_done_flag) && $stable(rx_error_flag)))
        else $error("flags moved while clock enable low");

    a_flag_clear_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && clr_tx_done && !evt.tx_done) |=> !tx_done_flag)
        else $error("transmit-complete flag not cleared");

    a_mask_blocks_irq: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rx_done_mask && tx_done_mask && rx_error_mask) |-> !irq_out)
        else $error("interrupt with every mask set");

    a_unmask_services: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (rx_error_flag && !rx_error_mask) |-> irq_out)
        else $error("unmasked error flag not serviced");

    a_tx_mask_blocks: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (tx_done_flag && tx_done_mask && !serv_rx_done && !serv_rx_error) |-> !irq_out)
        else $error("masked transmit-complete flag raised interrupt");

    a_rdata_returns_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && !req.rd) |=> (rdata_out == ucs_pkg::RDATA_RESET))
        else $error("read data stood without a read strobe");

    a_start_reads_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && req.rd && req.addr == ucs_pkg::ADDR_START) |=> (rdata_out == '0))
        else $error("start register read nonzero");

    a_start_enables: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && wr_start && req.wdata[0]) |=> channel_operation_enable[0] && channel_waiting[0])
        else $error("channel zero not started");

    a_upper_ignored: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && wr_start && req.wdata[ucs_pkg::CHAN_N-1:0] == '0) |=> $stable(channel_operation_enable))
        else $error("zero trigger changed enables");

    c_rx_irq: cover property (@(posedge clk_in) disable iff (!resetn_in)
        evt.rx_done ##1 (irq_out && serv_rx_done));
    c_set_and_clear: cover property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && clr_rx_error && evt.rx_error);
    c_channel_start: cover property (@(posedge clk_in) disable iff (!resetn_in)
        wr_start ##1 (channel_operation_enable == 4'hf));
    c_freeze_resume: cover property (@(posedge clk_in) disable iff (!resetn_in)
        !ce_in ##1 ce_in);

endmodule

/* File: design/ucs_pkg.sv */
// Purpose: shared constants and types for the serial channel start and interrupt block
// Assumes: 16-bit register port, word index addressing, one clock domain
// Notes: only the three request flags of the first channel pair are held; other flag bits read zero
package ucs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CHAN_N = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // register indices
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_HIGH_0 = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_LOW_1 = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MASKS_HIGH_0 = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_MASKS_LOW_1 = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_START = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STOP = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_RX_ENABLE = 4'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int RX_DONE_BIT = 7;  // in irq_flags_high_0 / irq_masks_high_0
    localparam int TX_DONE_BIT = 5;  // in irq_flags_high_0 / irq_masks_high_0
    localparam int RX_ERROR_BIT = 0; // in irq_flags_low_1 / irq_masks_low_1
    localparam int STATUS_WAIT_LSB = 4; // wait-state bits sit above the enable bits

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic FLAG_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b1;
    localparam logic [CHAN_N-1:0] ENABLE_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        CH_STOPPED = 2'b00,
        CH_WAIT = 2'b01
    } ucs_chan_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ucs_bus_req_s;

    typedef struct packed {
        logic rx_done;
        logic tx_done;
        logic rx_error;
    } ucs_events_s;

endpackage

/* File: design/ucs_chan_start.sv */
// Purpose: one serial channel's operation-enable bit and wait state
// Assumes: start and stop never arrive in the same cycle (separate register indices)
// Notes: state advances only while the clock enable is high
`timescale 1ns/1ps
module ucs_chan_start (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic stop_in,
    output logic enable_out,
    output logic waiting_out
);

    ucs_pkg::ucs_chan_state_e state;
    ucs_pkg::ucs_chan_state_e next_state;

    ////////////////////////////////////////////////////////////////////////////////
    // a start pulse enters the wait state; a zero trigger leaves the channel alone
    always_comb begin
        case (state)
            ucs_pkg::CH_STOPPED: next_state = start_in ? ucs_pkg::CH_WAIT : ucs_pkg::CH_STOPPED;
            ucs_pkg::CH_WAIT: next_state = stop_in ? ucs_pkg::CH_STOPPED : ucs_pkg::CH_WAIT;
            default: next_state = ucs_pkg::CH_STOPPED;
        endcase
    end

    // state register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= ucs_pkg::CH_STOPPED;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign enable_out = (state == ucs_pkg::CH_WAIT);
    assign waiting_out = (state == ucs_pkg::CH_WAIT);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_start_sets_enable: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (ce_in && start_in) |=> (enable_out && waiting_out))
        else $error("start trigger did not enable channel");

    a_idle_holds_enable: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (!start_in && !stop_in) |=> $stable(enable_out))
        else $error("enable changed without trigger");

endmodule

/* File: test/ucs_irq_ctrl_test.sv */
// Purpose: self-checking bench for the request flags, masks and channel start triggers
// Assumes: register port with one-cycle strobes, read data valid only in the cycle after the read
// Notes: clock enable is held high except in the freeze scenario; the block's own assertions watch the timing in between
`timescale 1ns/1ps
module ucs_irq_ctrl_test;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ce_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [15:0] rdata_out;
    logic irq_out;
    logic [3:0] channel_operation_enable_out;
    logic [3:0] receive_enable_bit_out;
    int mismatches = 0;
    int cmp_count = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and design under test
    always #4 clk_in = ~clk_in;

    ucs_irq_ctrl ucs_irq_ctrl_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .rx_done_request_in(ev[2]), .tx_done_request_in(ev[1]), .rx_error_request_in(ev[0]),
        .irq_out(irq_out), .channel_operation_enable_out(channel_operation_enable_out),
        .receive_enable_bit_out(receive_enable_bit_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // shared bus, event and compare tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one write cycle; the effect is settled one step after the taking edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so sample right there
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    task automatic pulse(input logic [2:0] e);
        @(posedge clk_in);
        ev <= e;
        @(posedge clk_in);
        ev <= 3'h0;
        #1;
    endtask

    // raise one unmasked event, see the interrupt, clear it by writing one
    task automatic svc(input logic [2:0] e, input logic [3:0] a, input logic [15:0] b);
        logic [15:0] d;
        pulse(e);
        chk({15'h0, irq_out}, 16'h0001);
        rd(a, d);
        chk(d, b);
        wr(a, b);
        chk({15'h0, irq_out}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset;
        logic [15:0] d;
        rd(4'h0, d);
        chk(d, 16'h0000);
        rd(4'h1, d);
        chk(d, 16'h0000);
        rd(4'h2, d);
        chk(d, 16'h00a0);
        rd(4'h3, d);
        chk(d, 16'h0001);
        chk({15'h0, irq_out}, 16'h0000);
        chk({12'h0, channel_operation_enable_out}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_events;
        logic [15:0] d;
        // masked events still latch but must not interrupt
        pulse(3'b100);
        rd(4'h0, d);
        chk(d, 16'h0080);
        pulse(3'b010);
        rd(4'h0, d);
        chk(d, 16'h00a0);
        pulse(3'b001);
        rd(4'h1, d);
        chk(d, 16'h0001);
        chk({15'h0, irq_out}, 16'h0000);
        // stale requests cleared before unmasking
        wr(4'h0, 16'h00a0);
        wr(4'h1, 16'h0001);
        rd(4'h0, d);
        chk(d, 16'h0000);
        rd(4'h1, d);
        chk(d, 16'h0000);
        wr(4'h2, 16'h0000);
        wr(4'h3, 16'h0000);
        chk({15'h0, irq_out}, 16'h0000);
        svc(3'b100, 4'h0, 16'h0080);
        svc(3'b010, 4'h0, 16'h0020);
        svc(3'b001, 4'h1, 16'h0001);
        // a pending flag becomes serviced when its mask drops
        wr(4'h2, 16'h0020);
        pulse(3'b010);
        chk({15'h0, irq_out}, 16'h0000);
        wr(4'h2, 16'h0000);
        chk({15'h0, irq_out}, 16'h0001);
        wr(4'h0, 16'h0020);
        $display("test events done");
    endtask

    task automatic test_start;
        logic [15:0] d;
        wr(4'h7, 16'h0001);
        chk({12'h0, receive_enable_bit_out}, 16'h0001);
        repeat (4) @(posedge clk_in);
        wr(4'h4, 16'h0001);
        chk({12'h0, channel_operation_enable_out}, 16'h0001);
        rd(4'h6, d);
        chk(d, 16'h0011);
        wr(4'h4, 16'h0000);
        rd(4'h6, d);
        chk(d, 16'h0011);
        wr(4'h4, 16'hfff2);
        chk({12'h0, channel_operation_enable_out}, 16'h0003);
        rd(4'h4, d);
        chk(d, 16'h0000);
        rd(4'h6, d);
        chk(d, 16'h0033);
        wr(4'h4, 16'h000c);
        chk({12'h0, channel_operation_enable_out}, 16'h000f);
        wr(4'h5, 16'h000f);
        chk({12'h0, channel_operation_enable_out}, 16'h0000);
        rd(4'h8, d);
        chk(d, 16'h0000);
        $display("test start done");
    endtask

    task automatic test_freeze;
        logic [15:0] d;
        // clock enable low: an event and a start write must both be ignored
        @(posedge clk_in);
        ce_in <= 1'b0;
        pulse(3'b100);
        wr(4'h4, 16'h0001);
        @(posedge clk_in);
        ce_in <= 1'b1;
        #1;
        chk({12'h0, channel_operation_enable_out}, 16'h0000);
        rd(4'h0, d);
        chk(d, 16'h0000);
        // event and write-one clear in the same cycle: the event wins
        @(posedge clk_in);
        ev <= 3'b001;
        wr_in <= 1'b1;
        addr_in <= 4'h1;
        wdata_in <= 16'h0001;
        @(posedge clk_in);
        ev <= 3'h0;
        wr_in <= 1'b0;
        #1;
        chk({15'h0, irq_out}, 16'h0001);
        rd(4'h1, d);
        chk(d, 16'h0001);
        wr(4'h1, 16'h0001);
        chk({15'h0, irq_out}, 16'h0000);
        $display("test freeze done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        test_reset();
        test_events();
        test_start();
        test_freeze();
        stop_test();
    end

    // all scenarios need well under a thousand cycles
    initial begin
        #20000;
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
